// >>> lpc_ctrl.v
// clock-mode selection, stabilization waits and standby sequencing
// assumes an APB master on pclk; oscillator and pin inputs are async
`timescale 1ns/1ps
`include "lpc_defs.vh"

module lpc_ctrl #(
   parameter [18:0] POR_WAIT = `LPC_POR_WAIT,
   parameter [18:0] PLL_WAIT = `LPC_PLL_WAIT,
   parameter [14:0] SUB_WAIT = `LPC_SUB_WAIT,
   parameter [18:0] WS0_WAIT = `LPC_WS0_WAIT,
   parameter [18:0] WS1_WAIT = `LPC_WS1_WAIT,
   parameter [18:0] WS2_WAIT = `LPC_WS2_WAIT,
   parameter [18:0] WS3_WAIT = `LPC_WS3_WAIT
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // pins and oscillator monitors
   input wire standby_pin_n,
   input wire ext_rst_n,
   input wire hclk_in,
   input wire sclk_in,
   // on-chip events
   input wire wdog_rst,
   input wire wake_irq,
   input wire cpu_access,
   // clock and pin controls
   output reg hosc_en,
   output reg sosc_en,
   output reg pll_en,
   output reg [1:0] mclk_sel,
   output reg cpu_clk_en,
   output reg periph_clk_en,
   output reg tbt_en,
   output reg wt_en,
   output reg pin_hiz,
   output reg hstby_active
);

   localparam [8:0] S_MSTAB = 9'h001;
   localparam [8:0] S_PSTAB = 9'h002;
   localparam [8:0] S_SSTAB = 9'h004;
   localparam [8:0] S_RUN = 9'h008;
   localparam [8:0] S_SLEEP = 9'h010;
   localparam [8:0] S_TBT = 9'h020;
   localparam [8:0] S_WATCH = 9'h040;
   localparam [8:0] S_STOP = 9'h080;
   localparam [8:0] S_HSTBY = 9'h100;

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a[11:2] == off[11:2]);
      end
   endfunction

   function [18:0] ws_len;
      input [1:0] s;
      begin
         case (s)
            2'h0: ws_len = WS0_WAIT;
            2'h1: ws_len = WS1_WAIT;
            2'h2: ws_len = WS2_WAIT;
            default: ws_len = WS3_WAIT;
         endcase
      end
   endfunction

   // synchronisers: standby pin, reset pin, oscillator monitors
   wire [3:0] raw_in;
   reg [3:0] meta_reg;
   reg [3:0] sync_reg;
   reg [1:0] prev_reg;
   assign raw_in = {sclk_in, hclk_in, ext_rst_n, standby_pin_n};

   localparam [3:0] SYNC_RST = `LPC_SYNC_RST;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_reg[gi] <= SYNC_RST[gi];
               sync_reg[gi] <= SYNC_RST[gi];
            end else begin
               meta_reg[gi] <= raw_in[gi];
               sync_reg[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prev_reg <= 2'h0;
      else
         prev_reg <= sync_reg[3:2];
   end

   // oscillator edges seen at pclk; the oscillators must run
   // below half of pclk or ticks are lost
   wire hclk_tick = sync_reg[2] & ~prev_reg[0];
   wire sclk_tick = sync_reg[3] & ~prev_reg[1];
   wire hstby_req = ~sync_reg[0];
   wire ext_rst = ~sync_reg[1];

   // state
   reg [8:0] state_reg;
   reg [1:0] mode_reg;
   reg pll_pend_reg;
   reg [18:0] tb_cnt_reg;
   reg [18:0] wait_tgt_reg;
   reg [14:0] wt_cnt_reg;
   reg [1:0] ws_reg;
   reg pll_sel_reg;
   reg sub_sel_reg;
   reg [1:0] cg_reg;
   reg hiz_sel_reg;
   reg [5:0] pause_reg;

   // apb decode
   wire acc = psel & penable;
   wire cs_hit = hit(paddr, `LPC_OFF_CLKSEL);
   wire lp_hit = hit(paddr, `LPC_OFF_LPMCTL);
   wire cs_wr = acc & pwrite & cs_hit;
   wire lp_wr = acc & pwrite & lp_hit;
   assign pready = 1'b1;
   assign pslverr = acc & ~(cs_hit | lp_hit);

   wire tb_done = (tb_cnt_reg == wait_tgt_reg);
   wire sub_ok = (wt_cnt_reg == SUB_WAIT);
   wire is_pll = (mode_reg == `LPC_MODE_PLL);
   wire is_sub = (mode_reg == `LPC_MODE_SUB);

   wire [1:0] want_mode = !sub_sel_reg ? `LPC_MODE_SUB :
                          !pll_sel_reg ? `LPC_MODE_PLL :
                          `LPC_MODE_MAIN;

   // read data captured in the setup phase, valid in access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= 32'h0;
         if (cs_hit) begin
            prdata[`LPC_CS_WS_HI:`LPC_CS_WS_LO] <= ws_reg;
            prdata[`LPC_CS_PLLSEL] <= pll_sel_reg;
            prdata[`LPC_CS_SUBSEL] <= sub_sel_reg;
            prdata[`LPC_CS_PLLACT] <= is_pll;
            prdata[`LPC_CS_SUBACT] <= is_sub;
         end else if (lp_hit) begin
            prdata[`LPC_LP_CG_HI:`LPC_LP_CG_LO] <= cg_reg;
            prdata[`LPC_LP_HIZ] <= hiz_sel_reg;
         end
      end
   end

   // sub oscillator stabilization, restarted whenever it stops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wt_cnt_reg <= 15'h0;
      else if (!sosc_en)
         wt_cnt_reg <= 15'h0;
      else if (sclk_tick && !sub_ok)
         wt_cnt_reg <= wt_cnt_reg + 15'h1;
   end

   // mode sequencer; requests are honoured only in S_RUN, so a
   // clock-select request made while a switch is pending waits for S_RUN; a low-power one is dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_MSTAB;
         mode_reg <= `LPC_MODE_MAIN;
         pll_pend_reg <= 1'b0;
         tb_cnt_reg <= 19'h0;
         wait_tgt_reg <= POR_WAIT;
         ws_reg <= `LPC_WS_RST;
         pll_sel_reg <= `LPC_SEL_RST;
         sub_sel_reg <= `LPC_SEL_RST;
         cg_reg <= `LPC_CG_RST;
         hiz_sel_reg <= 1'b0;
      end else if (hstby_req) begin
         state_reg <= S_HSTBY;
      end else if (wdog_rst && state_reg != S_HSTBY) begin
         state_reg <= S_MSTAB;
         mode_reg <= `LPC_MODE_MAIN;
         pll_pend_reg <= 1'b0;
         tb_cnt_reg <= 19'h0;
         wait_tgt_reg <= ws_len(ws_reg);
         pll_sel_reg <= `LPC_SEL_RST;
         sub_sel_reg <= `LPC_SEL_RST;
         cg_reg <= `LPC_CG_RST;
         hiz_sel_reg <= 1'b0;
      end else begin
         if (hclk_tick && !tb_done)
            tb_cnt_reg <= tb_cnt_reg + 19'h1;
         if (cs_wr) begin
            ws_reg <= pwdata[`LPC_CS_WS_HI:`LPC_CS_WS_LO];
            pll_sel_reg <= pwdata[`LPC_CS_PLLSEL];
            sub_sel_reg <= pwdata[`LPC_CS_SUBSEL];
         end
         if (lp_wr) begin
            cg_reg <= pwdata[`LPC_LP_CG_HI:`LPC_LP_CG_LO];
            hiz_sel_reg <= pwdata[`LPC_LP_HIZ];
         end
         case (state_reg)
            S_HSTBY: begin
               // pin released: restart like a watchdog reset
               state_reg <= S_MSTAB;
               mode_reg <= `LPC_MODE_MAIN;
               pll_pend_reg <= 1'b0;
               tb_cnt_reg <= 19'h0;
               wait_tgt_reg <= ws_len(ws_reg);
               pll_sel_reg <= `LPC_SEL_RST;
               sub_sel_reg <= `LPC_SEL_RST;
               cg_reg <= `LPC_CG_RST;
               hiz_sel_reg <= 1'b0;
            end
            S_MSTAB: begin
               if (tb_done) begin
                  mode_reg <= `LPC_MODE_MAIN;
                  if (pll_pend_reg) begin
                     pll_pend_reg <= 1'b0;
                     state_reg <= S_PSTAB;
                     tb_cnt_reg <= 19'h0;
                     wait_tgt_reg <= PLL_WAIT;
                  end else begin
                     state_reg <= S_RUN;
                  end
               end
            end
            S_PSTAB: begin
               if (tb_done) begin
                  mode_reg <= `LPC_MODE_PLL;
                  state_reg <= S_RUN;
               end
            end
            S_SSTAB: begin
               if (sub_ok) begin
                  mode_reg <= `LPC_MODE_SUB;
                  state_reg <= S_RUN;
               end
            end
            S_RUN: begin
               if (lp_wr && pwdata[`LPC_LP_STOP]) begin
                  state_reg <= is_pll ? S_TBT : S_STOP;
               end else if (lp_wr && pwdata[`LPC_LP_SLEEP]) begin
                  state_reg <= S_SLEEP;
               end else if (lp_wr && !pwdata[`LPC_LP_WATCH]) begin
                  state_reg <= S_WATCH;
               end else if (want_mode != mode_reg) begin
                  case (want_mode)
                     `LPC_MODE_SUB: begin
                        if (sub_ok)
                           mode_reg <= `LPC_MODE_SUB;
                        else
                           state_reg <= S_SSTAB;
                     end
                     `LPC_MODE_PLL: begin
                        tb_cnt_reg <= 19'h0;
                        if (is_sub) begin
                           pll_pend_reg <= 1'b1;
                           state_reg <= S_MSTAB;
                           wait_tgt_reg <= ws_len(ws_reg);
                        end else begin
                           state_reg <= S_PSTAB;
                           wait_tgt_reg <= PLL_WAIT;
                        end
                     end
                     default: begin
                        if (is_sub) begin
                           state_reg <= S_MSTAB;
                           tb_cnt_reg <= 19'h0;
                           wait_tgt_reg <= ws_len(ws_reg);
                        end else begin
                           mode_reg <= `LPC_MODE_MAIN;
                        end
                     end
                  endcase
               end
            end
            S_SLEEP: begin
               if (wake_irq || ext_rst)
                  state_reg <= S_RUN;
            end
            S_TBT: begin
               // oscillator kept running; only the PLL restarts
               if (wake_irq || ext_rst) begin
                  mode_reg <= `LPC_MODE_MAIN;
                  state_reg <= S_PSTAB;
                  tb_cnt_reg <= 19'h0;
                  wait_tgt_reg <= PLL_WAIT;
               end
            end
            S_WATCH, S_STOP: begin
               // external reset wakes stop but not watch
               if (wake_irq ||
                   (ext_rst && state_reg == S_STOP)) begin
                  if (is_sub) begin
                     state_reg <= S_SSTAB;
                  end else begin
                     pll_pend_reg <= is_pll;
                     state_reg <= S_MSTAB;
                     tb_cnt_reg <= 19'h0;
                     wait_tgt_reg <= ws_len(ws_reg);
                  end
               end
            end
            default: state_reg <= S_MSTAB;
         endcase
      end
   end

   // intermittent cpu operation
   wire cpu_live = (state_reg == S_RUN) | (state_reg == S_PSTAB) |
                   (state_reg == S_SSTAB);
   reg [5:0] halt_len;
   always @* begin
      case (cg_reg)
         2'h1: halt_len = `LPC_CG1_HALT;
         2'h2: halt_len = `LPC_CG2_HALT;
         2'h3: halt_len = `LPC_CG3_HALT;
         default: halt_len = 6'h00;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pause_reg <= 6'h0;
      else if (!cpu_live)
         pause_reg <= 6'h0;
      else if (pause_reg != 6'h0)
         pause_reg <= pause_reg - 6'h1;
      else if (cpu_access)
         pause_reg <= halt_len;
   end

   // clock and pin controls, registered
   reg hosc_next;
   reg sosc_next;
   reg pll_next;
   reg [1:0] mclk_next;
   reg cpu_next;
   reg periph_next;
   reg tbt_next;
   reg hiz_next;

   always @* begin
      hosc_next = ~is_sub;
      sosc_next = 1'b1;
      pll_next = is_pll;
      mclk_next = mode_reg;
      cpu_next = cpu_live & (pause_reg == 6'h0);
      periph_next = 1'b1;
      tbt_next = 1'b0;
      hiz_next = 1'b0;
      case (state_reg)
         S_MSTAB: begin
            hosc_next = 1'b1;
            pll_next = 1'b0;
            mclk_next = `LPC_MODE_MAIN;
            cpu_next = 1'b0;
            periph_next = 1'b0;
         end
         S_PSTAB: begin
            hosc_next = 1'b1;
            pll_next = 1'b1;
            mclk_next = `LPC_MODE_MAIN;
         end
         S_SLEEP: begin
            cpu_next = 1'b0;
         end
         S_TBT: begin
            hosc_next = 1'b1;
            // pll is off here, so never leave it selected
            mclk_next = `LPC_MODE_MAIN;
            pll_next = 1'b0;
            cpu_next = 1'b0;
            periph_next = 1'b0;
            tbt_next = 1'b1;
            hiz_next = hiz_sel_reg;
         end
         S_WATCH: begin
            hosc_next = 1'b0;
            mclk_next = `LPC_MODE_SUB;
            pll_next = 1'b0;
            cpu_next = 1'b0;
            periph_next = 1'b0;
            hiz_next = hiz_sel_reg;
         end
         S_STOP: begin
            hosc_next = 1'b0;
            sosc_next = 1'b0;
            pll_next = 1'b0;
            cpu_next = 1'b0;
            periph_next = 1'b0;
            hiz_next = hiz_sel_reg;
         end
         S_HSTBY: begin
            hosc_next = 1'b0;
            mclk_next = `LPC_MODE_MAIN;
            sosc_next = 1'b0;
            pll_next = 1'b0;
            cpu_next = 1'b0;
            periph_next = 1'b0;
            hiz_next = 1'b1;
         end
         default: begin
            tbt_next = 1'b0;
         end
      endcase
      if (hosc_next && state_reg != S_TBT)
         tbt_next = 1'b1;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hosc_en <= 1'b1;
         sosc_en <= 1'b1;
         pll_en <= 1'b0;
         mclk_sel <= `LPC_MODE_MAIN;
         cpu_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         tbt_en <= 1'b1;
         wt_en <= 1'b1;
         pin_hiz <= 1'b0;
         hstby_active <= 1'b0;
      end else begin
         hosc_en <= hosc_next;
         sosc_en <= sosc_next;
         pll_en <= pll_next;
         mclk_sel <= mclk_next;
         cpu_clk_en <= cpu_next;
         periph_clk_en <= periph_next;
         tbt_en <= tbt_next;
         wt_en <= sosc_next;
         pin_hiz <= hiz_next;
         hstby_active <= (state_reg == S_HSTBY);
      end
   end

endmodule

// >>> lpc_ctrl_chk.sv
// port-level assertions for the clock-mode and standby controller
// bound into lpc_ctrl; only the design's own ports are watched
`timescale 1ns/1ps
`include "lpc_defs.vh"
module lpc_ctrl_chk #(
   parameter [18:0] POR_WAIT = `LPC_POR_WAIT
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // standby pin
   input wire standby_pin_n,
   // clock and pin controls
   input wire hosc_en,
   input wire sosc_en,
   input wire pll_en,
   input wire [1:0] mclk_sel,
   input wire cpu_clk_en,
   input wire periph_clk_en,
   input wire tbt_en,
   input wire wt_en,
   input wire pin_hiz,
   input wire hstby_active
);
   reg first_reg;
   reg [19:0] cnt_reg;
   // oscillator edges arrive at most every second pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_reg <= 1'h1;
         cnt_reg <= 20'h00000;
      end else if (cpu_clk_en) begin
         first_reg <= 1'h0;
      end else if (first_reg) begin
         cnt_reg <= cnt_reg + 20'h00001;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_por_wait_len: assert property (
      $rose(cpu_clk_en) && first_reg |-> cnt_reg >= {POR_WAIT - 19'h1, 1'h0})
      else $error("cpu started before power-on wait");
   chk_hstby_entry: assert property (
      !standby_pin_n [*6] |-> hstby_active)
      else $error("standby pin low but no standby");
   chk_hstby_hold: assert property (
      hstby_active && !standby_pin_n |=> hstby_active)
      else $error("standby left while pin low");
   chk_hstby_off: assert property (
      hstby_active |-> pin_hiz && !hosc_en && !sosc_en && !pll_en)
      else $error("standby with oscillator on or pins driven");
   chk_cpu_stopped: assert property (
      hstby_active || !periph_clk_en |-> !cpu_clk_en)
      else $error("cpu clocked in standby");
   chk_pll_source: assert property (
      mclk_sel == `LPC_MODE_PLL |-> pll_en && hosc_en)
      else $error("pll machine clock without pll");
   chk_main_source: assert property (
      mclk_sel == `LPC_MODE_MAIN && cpu_clk_en |-> hosc_en)
      else $error("main clock without fast oscillator");
   chk_sub_source: assert property (
      mclk_sel == `LPC_MODE_SUB && periph_clk_en |-> sosc_en && wt_en)
      else $error("sub clock without sub oscillator");
   chk_stop_quiet: assert property (
      !hosc_en && !sosc_en |-> !tbt_en && !wt_en && !cpu_clk_en)
      else $error("clock running with both oscillators off");
   chk_timer_osc: assert property (
      !(tbt_en && !hosc_en) && !(wt_en && !sosc_en))
      else $error("timer running without its oscillator");
endmodule
bind lpc_ctrl lpc_ctrl_chk #(.POR_WAIT(POR_WAIT)) chk (.pclk(pclk),
   .presetn(presetn), .standby_pin_n(standby_pin_n), .hosc_en(hosc_en),
   .sosc_en(sosc_en), .pll_en(pll_en), .mclk_sel(mclk_sel),
   .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
   .tbt_en(tbt_en), .wt_en(wt_en), .pin_hiz(pin_hiz),
   .hstby_active(hstby_active));

// >>> lpc_defs.vh
// register map, field positions, reset values and wait lengths
// for the clock-mode and standby controller; definitions only
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// register byte offsets
`define LPC_OFF_CLKSEL 12'h000
`define LPC_OFF_LPMCTL 12'h004

// clock_select_reg fields
`define LPC_CS_WS_LO 0
`define LPC_CS_WS_HI 1
`define LPC_CS_PLLSEL 2
`define LPC_CS_SUBSEL 3
`define LPC_CS_PLLACT 6
`define LPC_CS_SUBACT 7

// low-power control register fields
`define LPC_LP_CG_LO 1
`define LPC_LP_CG_HI 2
`define LPC_LP_WATCH 3
`define LPC_LP_HIZ 5
`define LPC_LP_SLEEP 6
`define LPC_LP_STOP 7

// reset values
`define LPC_WS_RST 2'h0
`define LPC_SEL_RST 1'h1
`define LPC_CG_RST 2'h0
`define LPC_SYNC_RST 4'h3

// machine clock select codes
`define LPC_MODE_MAIN 2'h0
`define LPC_MODE_PLL 2'h1
`define LPC_MODE_SUB 2'h2

// waits in oscillator periods
`define LPC_POR_WAIT 19'h40000
`define LPC_PLL_WAIT 19'h02000
`define LPC_SUB_WAIT 15'h4000
`define LPC_WS0_WAIT 19'h00400
`define LPC_WS1_WAIT 19'h02000
`define LPC_WS2_WAIT 19'h08000
`define LPC_WS3_WAIT 19'h20000

// cpu halt lengths in intermittent operation
`define LPC_CG1_HALT 6'h09
`define LPC_CG2_HALT 6'h11
`define LPC_CG3_HALT 6'h21

`endif

// >>> lpc_osc_model.sv
// stand-ins for the fast and sub oscillators seen by the controller
// a stopped oscillator holds its output low; slow halves the fast rate and stretches the sub half-period from 170 to 330
`timescale 1ns/1ps
module lpc_osc_model (
   // enables from the controller; slow comes from the bench
   input wire hosc_en,
   input wire sosc_en,
   input wire slow,
   // oscillator outputs
   output reg hclk_in,
   output reg sclk_in
);
   initial begin
      hclk_in = 1'h0;
      sclk_in = 1'h0;
   end
   // kept under half of pclk so the sampled monitor sees every edge
   always begin
      #(slow === 1'h1 ? 100 : 50);
      hclk_in = hosc_en ? ~hclk_in : 1'h0;
   end
   always begin
      #(slow === 1'h1 ? 330 : 170);
      sclk_in = sosc_en ? ~sclk_in : 1'h0;
   end
endmodule

// >>> test_low_power_clock_mode_control.sv
// self-checking bench for the clock-mode and standby controller
// needs lpc_ctrl, its bound checker and the oscillator stand-in
`timescale 1ns/1ps
`include "lpc_defs.vh"
module test_low_power_clock_mode_control;
   localparam [18:0] POR_W = 19'h00010;
   localparam [18:0] WS3_W = 19'h00010;
   reg pclk = 1'h0;
   reg presetn = 1'h0;
   reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg standby_pin_n = 1'h1, ext_rst_n = 1'h1, wdog_rst = 1'h0;
   reg wake_irq = 1'h0, cpu_access = 1'h0, slow = 1'h0;
   wire [31:0] prdata;
   wire pready, pslverr, hclk_in, sclk_in, hosc_en, sosc_en, pll_en;
   wire cpu_clk_en, periph_clk_en, tbt_en, wt_en, pin_hiz, hstby_active;
   wire [1:0] mclk_sel;
   wire [7:0] outs = {hosc_en, sosc_en, pll_en, tbt_en, wt_en, cpu_clk_en,
      periph_clk_en, pin_hiz};
   reg [31:0] rq, ws;
   reg re;
   integer n_mismatch = 0, n_checks = 0, cyc, c0, n, k, cg;
   lpc_ctrl #(.POR_WAIT(POR_W), .PLL_WAIT(19'h8), .SUB_WAIT(15'h8),
      .WS0_WAIT(19'h4), .WS1_WAIT(19'h8), .WS2_WAIT(19'hC),
      .WS3_WAIT(WS3_W)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .standby_pin_n(standby_pin_n),
      .ext_rst_n(ext_rst_n), .hclk_in(hclk_in), .sclk_in(sclk_in),
      .wdog_rst(wdog_rst), .wake_irq(wake_irq), .cpu_access(cpu_access),
      .hosc_en(hosc_en), .sosc_en(sosc_en), .pll_en(pll_en),
      .mclk_sel(mclk_sel), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .tbt_en(tbt_en), .wt_en(wt_en),
      .pin_hiz(pin_hiz), .hstby_active(hstby_active));
   lpc_osc_model osc (.hosc_en(hosc_en), .sosc_en(sosc_en), .slow(slow),
      .hclk_in(hclk_in), .sclk_in(sclk_in));
   // timers follow their oscillators, so the table needs six inputs
   function [7:0] expo(input h, input s, input p, input c, input f,
      input z);
      expo = {h, s, p, h, s, c, f, z};
   endfunction
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'h1;
         penable <= 1'h0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         // access phase: answer taken at the edge that sees penable high
         @(posedge pclk);
         for (k = 0; k < 16 && pready !== 1'h1; k = k + 1)
            @(posedge pclk);
         rq = prdata;
         re = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         check(pready, 1'h1);
      end
   endtask
   task wait_cpu;
      for (cyc = 0; cpu_clk_en !== 1'h1 && cyc < 3000; cyc = cyc + 1)
         @(posedge pclk);
      check(cpu_clk_en, 1'h1);
   endtask
   task poll(input [31:0] want);
      begin
         for (n = 0; n < 200 && (n == 0 || (rq & 32'hC0) !== want); n++)
            apb(1'h0, 12'h000, 32'h0);
         check(rq & 32'hC0, want);
      end
   endtask
   task wake;
      begin
         @(posedge pclk);
         wake_irq <= 1'h1;
         repeat (2) @(posedge pclk);
         wake_irq <= 1'h0;
         wait_cpu;
      end
   endtask
   task mode(input [31:0] d, input [7:0] exp);
      begin
         apb(1'h1, 12'h004, d);
         repeat (3) @(posedge pclk);
         check(outs, exp);
      end
   endtask
   task results;
      begin
         if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      forever #20 pclk = ~pclk;
   end
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      results;
   end
   initial begin
      void'($urandom(32'hF14E3705));
      repeat (8) @(posedge pclk);
      check(outs, expo(1, 1, 0, 0, 0, 0));
      presetn <= 1'h1;
      wait_cpu;
      check(cyc >= 2 * (POR_W - 1), 1);
      check(outs, expo(1, 1, 0, 1, 1, 0));
      ws = $urandom_range(3, 0);
      apb(1'h1, 12'h000, 32'hCC | ws);
      apb(1'h0, 12'h000, 32'h0);
      check(rq, 32'h0C | ws);
      k = $urandom_range(1023, 2);
      apb(1'h0, {k[9:0], 2'h0}, 32'h0);
      check(rq, 32'h0);
      check(re, 1'h1);
      slow <= 1'h1;
      apb(1'h1, 12'h000, 32'h08 | ws);
      repeat (3) @(posedge pclk);
      check({cpu_clk_en, mclk_sel}, {1'h1, `LPC_MODE_MAIN});
      poll(32'h40);
      check({outs, mclk_sel}, {expo(1, 1, 1, 1, 1, 0), `LPC_MODE_PLL});
      slow <= 1'h0;
      mode(32'h48, expo(1, 1, 1, 0, 1, 0));
      wake;
      for (cg = 1; cg < 4; cg = cg + 1) begin
         apb(1'h1, 12'h004, 32'h08 | (cg << 1));
         @(posedge pclk);
         cpu_access <= 1'h1;
         @(posedge pclk);
         cpu_access <= 1'h0;
         c0 = 0;
         for (k = 0; k < 80; k = k + 1) begin
            @(posedge pclk);
            if (cpu_clk_en === 1'h0)
               c0 = c0 + 1;
            else if (c0 > 0)
               k = 80;
         end
         check({periph_clk_en, c0[7:0]}, 9'h100 | (8'h4 << cg) + 1);
      end
      mode(32'hE8, expo(1, 1, 0, 0, 0, 1));
      wake;
      poll(32'h40);
      apb(1'h1, 12'h000, 32'h0C | ws);
      poll(32'h00);
      mode(32'h88, expo(0, 0, 0, 0, 0, 0));
      wake;
      apb(1'h1, 12'h000, 32'h04);
      poll(32'h80);
      check(outs, expo(0, 1, 0, 1, 1, 0));
      mode(32'h48, expo(0, 1, 0, 0, 1, 0));
      wake;
      mode(32'h00, expo(0, 1, 0, 0, 0, 0));
      ext_rst_n <= 1'h0;
      repeat (6) @(posedge pclk);
      ext_rst_n <= 1'h1;
      repeat (4) @(posedge pclk);
      check(outs, expo(0, 1, 0, 0, 0, 0));
      wake;
      apb(1'h1, 12'h000, 32'h0C);
      poll(32'h00);
      standby_pin_n <= 1'h0;
      repeat (28) @(posedge pclk);
      check({hstby_active, outs}, {1'h1, expo(0, 0, 0, 0, 0, 1)});
      standby_pin_n <= 1'h1;
      wait_cpu;
      c0 = cyc;
      // pll request still pending when the watchdog fires
      apb(1'h1, 12'h000, 32'h0B);
      @(posedge pclk);
      wdog_rst <= 1'h1;
      @(posedge pclk);
      wdog_rst <= 1'h0;
      repeat (3) @(posedge pclk);
      check(cpu_clk_en, 1'h0);
      wait_cpu;
      check(c0 < 2 * (WS3_W - 1) && cyc >= 2 * (WS3_W - 2), 1);
      apb(1'h0, 12'h000, 32'h0);
      check(rq, 32'h0F);
      results;
   end
endmodule
